// ==== logic/dce_dma_channel_engine.sv ====
// Eight-channel DMA engine with APB register file and bus master
//
// Overview of operation
// - Eight channel blocks from 0xA0000008, each 0x14 bytes apart.
// - Config, count, peripheral and memory address at 0x0..0xC, reset zero.
// - Config bit 0 enables the channel; cleared, no requests served.
// - Bit 1 enables the completion interrupt.
// - Bit 2 enables the half-count interrupt.
// - Bit 3 enables the transfer error interrupt.
// - Bit 4 zero reads peripheral writes memory; one the reverse.
// - Bit 5 restarts the channel automatically after the count ends.
// - Bit 6 steps the peripheral address by item size each item.
// - Bit 7 steps the memory address by item size each item.
// - Bits 9:8 set peripheral width; wider items force alignment.
// - Bits 11:10 set memory width with the same encoding and alignment.
// - Bits 13:12 set priority, low to very high.
// - Bit 14 selects memory-to-memory; cleared, transfers are peripheral-paced.
// - Count writable only while disabled; reads remaining count.
// - Count decrements by one after each completed item.
// - At the end count stays zero, or reloads in circular mode.
// - A zero count serves nothing, enabled or not.
// - Global clear bit clears all four flags of the channel.
// - Individual clear bits clear only their own flag.
//
// Implementation choice: the APB interface to the registers.
`default_nettype none
module dce_dma_channel_engine #(
    parameter int NCH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Peripheral request lines and item acknowledge
    input wire logic [NCH-1:0] periph_req,
    output logic [NCH-1:0] periph_ack,
    // System bus master
    output logic m_req,
    output logic m_we,
    output logic [31:0] m_addr,
    output logic [1:0] m_size,
    output logic [31:0] m_wdata,
    input wire logic m_ready,
    input wire logic [31:0] m_rdata,
    input wire logic m_err,
    // Per-channel interrupt requests
    output logic [NCH-1:0] irq
);
    localparam int CW = $clog2(NCH);

    typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_WR} dce_state_t;

    localparam int CNT_W_L = dce_pkg::CNT_W;
    logic [31:0] cfg_q [NCH];
    logic [CNT_W_L-1:0] cnt_q [NCH];
    logic [CNT_W_L-1:0] rld_q [NCH];
    logic [31:0] pa_q [NCH];
    logic [31:0] ma_q [NCH];
    logic [31:0] cur_pa_q [NCH];
    logic [31:0] cur_ma_q [NCH];
    logic [4*NCH-1:0] flags_q;
    dce_state_t state_q;
    logic [CW-1:0] ch_q;
    logic grant_v;
    logic [CW-1:0] grant_ch;
    logic [1:0] best_pri;
    logic item_done;
    logic bus_err;
    logic apb_wr;
    logic apb_setup;
    dce_pkg::dce_dec_t dec_a;

    // Channel register decode; the gap at 0x10 of each block stays unmapped
    function automatic dce_pkg::dce_dec_t decode(input logic [31:0] a);
        logic [31:0] base;
        decode = '0;
        for (int i = 0; i < NCH; i++) begin
            base = dce_pkg::PERIPH_BASE + 32'(dce_pkg::CH_BASE)
                + 32'(i) * 32'(dce_pkg::CH_STRIDE);
            for (int r = 0; r < 4; r++) begin
                if (a == base + 32'(r) * 32'h4) begin
                    decode.hit = 1'b1;
                    decode.ch = 3'(i);
                    decode.idx = 2'(r);
                end
            end
        end
    endfunction

    // Forces alignment by dropping low address bits
    function automatic logic [31:0] align(input logic [31:0] a,
                                          input logic [1:0] w);
        case (w)
            dce_pkg::W16: align = {a[31:1], 1'b0};
            dce_pkg::W32: align = {a[31:2], 2'b00};
            default: align = a;
        endcase
    endfunction

    // Address step of one item
    function automatic logic [31:0] step(input logic [1:0] w);
        case (w)
            dce_pkg::W16: step = 32'h00000002;
            dce_pkg::W32: step = 32'h00000004;
            default: step = 32'h00000001;
        endcase
    endfunction

    // Keeps only the bits of one item
    function automatic logic [31:0] trim(input logic [31:0] d,
                                         input logic [1:0] w);
        case (w)
            dce_pkg::W8: trim = {24'h000000, d[7:0]};
            dce_pkg::W16: trim = {16'h0000, d[15:0]};
            default: trim = d;
        endcase
    endfunction

    // APB phases; zero wait states so access always completes
    assign pready = 1'b1;
    assign apb_setup = psel && !penable;
    assign apb_wr = psel && penable && pwrite;
    assign dec_a = decode(paddr);

    // Engine events, valid only while a bus beat completes
    assign item_done = (state_q == ST_WR) && m_ready && !m_err;
    assign bus_err = (state_q != ST_IDLE) && m_ready && m_err;

    // Arbitration; scanning downward lets the lower channel win a tie
    always_comb begin
        grant_v = 1'b0;
        grant_ch = '0;
        best_pri = 2'h0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (cfg_q[i][dce_pkg::EN_BIT]
                && cnt_q[i] != '0
                && (cfg_q[i][dce_pkg::COPY_BIT] || periph_req[i])
                && (!grant_v
                    || cfg_q[i][dce_pkg::PRI_LSB+:2] >= best_pri)) begin
                grant_v = 1'b1;
                grant_ch = CW'(i);
                best_pri = cfg_q[i][dce_pkg::PRI_LSB+:2];
            end
        end
    end

    // Channel registers; engine updates come last so hardware wins
    always_ff @(posedge clk) begin
        for (int i = 0; i < NCH; i++) begin
            if (rst) begin
                cfg_q[i] <= dce_pkg::REG_RESET;
                cnt_q[i] <= '0;
                rld_q[i] <= '0;
                pa_q[i] <= dce_pkg::REG_RESET;
                ma_q[i] <= dce_pkg::REG_RESET;
                cur_pa_q[i] <= dce_pkg::REG_RESET;
                cur_ma_q[i] <= dce_pkg::REG_RESET;
            end else begin
                if (apb_wr && dec_a.hit && dec_a.ch == 3'(i)) begin
                    case (dec_a.idx)
                        dce_pkg::CFG_IDX: begin
                            // Reserved bits are dropped on write
                            cfg_q[i] <= pwdata & dce_pkg::CFG_MASK;
                            if (pwdata[dce_pkg::EN_BIT]
                                && !cfg_q[i][dce_pkg::EN_BIT]) begin
                                cur_pa_q[i] <= pa_q[i];
                                cur_ma_q[i] <= ma_q[i];
                            end
                        end
                        dce_pkg::CNT_IDX: begin
                            if (!cfg_q[i][dce_pkg::EN_BIT]) begin
                                cnt_q[i] <= pwdata[CNT_W_L-1:0];
                                rld_q[i] <= pwdata[CNT_W_L-1:0];
                            end
                        end
                        dce_pkg::PA_IDX: pa_q[i] <= pwdata;
                        dce_pkg::MA_IDX: ma_q[i] <= pwdata;
                        default: ;
                    endcase
                end
                if (bus_err && ch_q == CW'(i)) begin
                    cfg_q[i][dce_pkg::EN_BIT] <= 1'b0;
                end
                if (item_done && ch_q == CW'(i)) begin
                    if (cnt_q[i] == CNT_W_L'(1)
                        && cfg_q[i][dce_pkg::WRAP_BIT]) begin
                        // Circular restart from the programmed values
                        cnt_q[i] <= rld_q[i];
                        cur_pa_q[i] <= pa_q[i];
                        cur_ma_q[i] <= ma_q[i];
                    end else begin
                        cnt_q[i] <= cnt_q[i] - CNT_W_L'(1);
                        if (cfg_q[i][dce_pkg::PSTEP_BIT]) begin
                            cur_pa_q[i] <= cur_pa_q[i]
                                + step(cfg_q[i][dce_pkg::PW_LSB+:2]);
                        end
                        if (cfg_q[i][dce_pkg::MSTEP_BIT]) begin
                            cur_ma_q[i] <= cur_ma_q[i]
                                + step(cfg_q[i][dce_pkg::MW_LSB+:2]);
                        end
                    end
                end
            end
        end
    end

    // Transfer sequencer: one read beat then one write beat per item
    always_ff @(posedge clk) begin
        logic [CW-1:0] g;
        logic rd_mem;
        logic [1:0] sw;
        logic [1:0] dw;
        logic to_periph;
        g = grant_ch;
        rd_mem = cfg_q[g][dce_pkg::DIR_BIT] || cfg_q[g][dce_pkg::COPY_BIT];
        sw = rd_mem ? cfg_q[g][dce_pkg::MW_LSB+:2]
                    : cfg_q[g][dce_pkg::PW_LSB+:2];
        // Write side follows the channel in flight; the grant may move on
        to_periph = cfg_q[ch_q][dce_pkg::DIR_BIT]
            || cfg_q[ch_q][dce_pkg::COPY_BIT];
        dw = to_periph ? cfg_q[ch_q][dce_pkg::PW_LSB+:2]
                       : cfg_q[ch_q][dce_pkg::MW_LSB+:2];
        if (rst) begin
            state_q <= ST_IDLE;
            ch_q <= '0;
            m_req <= 1'b0;
            m_we <= 1'b0;
            m_addr <= 32'h00000000;
            m_size <= dce_pkg::W8;
            m_wdata <= 32'h00000000;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (grant_v) begin
                        ch_q <= g;
                        m_req <= 1'b1;
                        m_we <= 1'b0;
                        m_size <= sw;
                        // Direction picks the source side
                        m_addr <= rd_mem
                            ? align(cur_ma_q[g], sw)
                            : align(cur_pa_q[g], sw);
                        state_q <= ST_RD;
                    end
                end
                ST_RD: begin
                    if (m_ready && m_err) begin
                        m_req <= 1'b0;
                        state_q <= ST_IDLE;
                    end else if (m_ready) begin
                        m_we <= 1'b1;
                        m_size <= dw;
                        m_wdata <= trim(m_rdata, dw);
                        m_addr <= to_periph
                            ? align(cur_pa_q[ch_q], dw)
                            : align(cur_ma_q[ch_q], dw);
                        state_q <= ST_WR;
                    end
                end
                ST_WR: begin
                    if (m_ready) begin
                        m_req <= 1'b0;
                        m_we <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Acknowledge pulse tells the paced peripheral one item is done
    always_ff @(posedge clk) begin
        for (int i = 0; i < NCH; i++) begin
            if (rst) begin
                periph_ack[i] <= 1'b0;
            end else begin
                periph_ack[i] <= item_done && ch_q == CW'(i)
                    && !cfg_q[i][dce_pkg::COPY_BIT];
            end
        end
    end

    // Event flags; a set in the same cycle as a clear survives
    always_ff @(posedge clk) begin
        logic [3:0] set;
        logic [3:0] clr;
        logic mine;
        for (int i = 0; i < NCH; i++) begin
            mine = ch_q == CW'(i);
            set = 4'h0;
            set[dce_pkg::F_DONE] = item_done && mine
                && cnt_q[i] == CNT_W_L'(1);
            set[dce_pkg::F_HALF] = item_done && mine
                && cnt_q[i] - CNT_W_L'(1) == (rld_q[i] >> 1);
            set[dce_pkg::F_ERR] = bus_err && mine;
            set[dce_pkg::F_GLB] = |set;
            clr = 4'h0;
            if (apb_wr && paddr == dce_pkg::PERIPH_BASE
                + 32'(dce_pkg::CLEAR_OFF)) begin
                clr = pwdata[4*i+:4];
                if (pwdata[4*i+dce_pkg::F_GLB]) begin
                    clr = 4'hF;
                end
            end
            if (rst) begin
                flags_q[4*i+:4] <= 4'h0;
            end else begin
                flags_q[4*i+:4] <= (flags_q[4*i+:4] & ~clr) | set;
            end
        end
    end

    // Interrupt requests gated by the interrupt enable bits
    always_ff @(posedge clk) begin
        for (int i = 0; i < NCH; i++) begin
            if (rst) begin
                irq[i] <= 1'b0;
            end else begin
                irq[i] <= (flags_q[4*i+dce_pkg::F_DONE]
                           && cfg_q[i][dce_pkg::DONE_IE_BIT])
                    || (flags_q[4*i+dce_pkg::F_HALF]
                        && cfg_q[i][dce_pkg::HALF_IE_BIT])
                    || (flags_q[4*i+dce_pkg::F_ERR]
                        && cfg_q[i][dce_pkg::ERR_IE_BIT]);
            end
        end
    end

    // Read data and error captured in the setup phase
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (apb_setup) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            if (dec_a.hit) begin
                case (dec_a.idx)
                    dce_pkg::CFG_IDX: prdata <= cfg_q[dec_a.ch];
                    dce_pkg::CNT_IDX: prdata <= 32'(cnt_q[dec_a.ch]);
                    dce_pkg::PA_IDX: prdata <= pa_q[dec_a.ch];
                    default: prdata <= ma_q[dec_a.ch];
                endcase
            end else if (paddr == dce_pkg::PERIPH_BASE
                         + 32'(dce_pkg::STATUS_OFF)) begin
                prdata <= 32'(flags_q);
            end else if (paddr != dce_pkg::PERIPH_BASE
                         + 32'(dce_pkg::CLEAR_OFF)) begin
                pslverr <= 1'b1; // Unmapped address
            end
        end
    end
endmodule
`default_nettype wire

// ==== logic/dce_pkg.sv ====
// Constants and types shared by the DMA channel engine
`default_nettype none
package dce_pkg;
    // Peripheral window and register layout
    localparam logic [31:0] PERIPH_BASE = 32'hA0000000;
    localparam logic [11:0] STATUS_OFF = 12'h000;
    localparam logic [11:0] CLEAR_OFF = 12'h004;
    localparam logic [11:0] CH_BASE = 12'h008;
    localparam logic [11:0] CH_STRIDE = 12'h014;
    localparam logic [1:0] CFG_IDX = 2'h0;
    localparam logic [1:0] CNT_IDX = 2'h1;
    localparam logic [1:0] PA_IDX = 2'h2;
    localparam logic [1:0] MA_IDX = 2'h3;
    localparam logic [31:0] REG_RESET = 32'h00000000;
    // Configuration fields
    localparam int EN_BIT = 0;
    localparam int DONE_IE_BIT = 1;
    localparam int HALF_IE_BIT = 2;
    localparam int ERR_IE_BIT = 3;
    localparam int DIR_BIT = 4;
    localparam int WRAP_BIT = 5;
    localparam int PSTEP_BIT = 6;
    localparam int MSTEP_BIT = 7;
    localparam int PW_LSB = 8;
    localparam int MW_LSB = 10;
    localparam int PRI_LSB = 12;
    localparam int COPY_BIT = 14;
    localparam logic [31:0] CFG_MASK = 32'h00007FFF;
    localparam int CNT_W = 16;
    // Flag positions inside each channel nibble
    localparam int F_GLB = 0;
    localparam int F_DONE = 1;
    localparam int F_HALF = 2;
    localparam int F_ERR = 3;
    // Item widths
    localparam logic [1:0] W8 = 2'h0;
    localparam logic [1:0] W16 = 2'h1;
    localparam logic [1:0] W32 = 2'h2;
    // Register decode result
    typedef struct packed {
        logic hit;
        logic [2:0] ch;
        logic [1:0] idx;
    } dce_dec_t;
endpackage
`default_nettype wire

// ==== tb/dce_dma_channel_engine_sva.sv ====
// Port-level checks on the DMA channel engine
`default_nettype none
module dce_dma_channel_engine_sva #(
    parameter int NCH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB side
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] paddr,
    input wire logic pslverr,
    // Bus master side
    input wire logic [NCH-1:0] periph_ack,
    input wire logic m_req,
    input wire logic m_we,
    input wire logic [31:0] m_addr,
    input wire logic [1:0] m_size,
    input wire logic m_ready,
    input wire logic m_err
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic rd_done;
    logic wr_done;
    // Beat completions seen at an edge
    assign rd_done = m_req && m_ready && !m_we;
    assign wr_done = m_req && m_ready && m_we;

    AST_RD_THEN_WR: assert property (
        rd_done && !m_err |=> m_req && m_we)
        else $error("no write beat after a good read beat");
    AST_HOLD: assert property (
        m_req && !m_ready |=> m_req && $stable(m_addr) && $stable(m_we)
            && $stable(m_size))
        else $error("bus request changed before ready");
    AST_ERR_STOP: assert property (
        rd_done && m_err |=> !m_req)
        else $error("bus activity went on after an error");
    AST_GAP: assert property (
        wr_done |=> !m_req)
        else $error("no idle cycle after an item");
    AST_ACK: assert property (
        |periph_ack |-> $past(wr_done) && $onehot(periph_ack))
        else $error("acknowledge without a finished write");
    AST_ALIGN16: assert property (
        m_req && m_size == 2'h1 |-> !m_addr[0])
        else $error("halfword beat on odd address");
    AST_ALIGN32: assert property (
        m_req && m_size == 2'h2 |-> m_addr[1:0] == 2'h0)
        else $error("word beat on unaligned address");
    AST_UNMAPPED: assert property (
        psel && !penable && paddr == 32'hA0000018 |=> pslverr)
        else $error("gap after a channel block not refused");
    AST_MAPPED: assert property (
        psel && !penable && paddr == 32'hA0000094 |=> !pslverr)
        else $error("last channel block refused");
    // Main scenarios reached
    cover property (wr_done);
    cover property (rd_done && m_err);
    cover property (|periph_ack);
endmodule
bind dce_dma_channel_engine dce_dma_channel_engine_sva #(.NCH(NCH)) sva_u (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .paddr(paddr),
    .pslverr(pslverr), .periph_ack(periph_ack), .m_req(m_req),
    .m_we(m_we), .m_addr(m_addr), .m_size(m_size), .m_ready(m_ready),
    .m_err(m_err)
);
`default_nettype wire

// ==== tb/dce_bus_model.sv ====
// Behavioural system bus slave standing for memory and peripherals
`default_nettype none
module dce_bus_model (
    // Clock, reset and pacing
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    // Bus from the engine
    input wire logic m_req,
    input wire logic m_we,
    input wire logic [31:0] m_addr,
    input wire logic [1:0] m_size,
    input wire logic [31:0] m_wdata,
    output logic m_ready,
    output logic [31:0] m_rdata,
    output logic m_err,
    // Write log for the bench
    output var int wr_count,
    output logic [31:0] last_waddr,
    output logic [31:0] last_wdata
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] wait_q;
    logic [31:0] cyc_q;
    logic [31:0] item;
    // Ready at once, or after two stalls so the hold is exercised
    assign m_ready = m_req && (!slow || wait_q == 2'h2);
    // Top region 0xE answers with an error
    assign m_err = m_ready && m_addr[31:28] == 4'hE;
    // Read data right-justified to the beat size
    assign item = m_size == 2'h0 ? {24'h000000, ~m_addr[7:0]} :
        m_size == 2'h1 ? {16'h0000, ~m_addr[15:0]} : ~m_addr;
    // Noise outside a ready beat; a stale value would hide late sampling
    assign m_rdata = m_ready ? item : cyc_q ^ 32'h5A5A5A5A;
    // Stall counter, noise source and write log
    always_ff @(posedge clk) begin
        if (rst) begin
            wait_q <= 2'h0;
            cyc_q <= 32'h00000000;
            wr_count <= 0;
        end else begin
            cyc_q <= cyc_q + 32'h00000001;
            wait_q <= (m_req && !m_ready) ? wait_q + 2'h1 : 2'h0;
            if (m_ready && m_we && !m_err) begin
                wr_count <= wr_count + 1;
                last_waddr <= m_addr;
                last_wdata <= m_wdata;
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb/dce_dma_channel_engine_test.sv ====
// Self-checking bench for the DMA channel engine
`default_nettype none
module dce_dma_channel_engine_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic slow = 1'b0;
    logic [31:0] paddr = 32'h00000000;
    logic [31:0] pwdata = 32'h00000000;
    logic [7:0] periph_req = 8'h00;
    logic pready, pslverr, m_req, m_we, m_ready, m_err, err_q;
    logic [31:0] prdata, m_addr, m_wdata, m_rdata, rd_q, last_waddr;
    logic [31:0] last_wdata;
    logic [1:0] m_size;
    logic [7:0] periph_ack, irq;
    int wr_count, base, i, j;
    int num_errors = 0;
    int check_count = 0;
    int acks = 0;

    dce_dma_channel_engine #(.NCH(8)) dut_u (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .periph_req(periph_req),
        .periph_ack(periph_ack), .m_req(m_req), .m_we(m_we),
        .m_addr(m_addr), .m_size(m_size), .m_wdata(m_wdata),
        .m_ready(m_ready), .m_rdata(m_rdata), .m_err(m_err), .irq(irq)
    );
    dce_bus_model bus_u (
        .clk(clk), .rst(rst), .slow(slow), .m_req(m_req), .m_we(m_we),
        .m_addr(m_addr), .m_size(m_size), .m_wdata(m_wdata),
        .m_ready(m_ready), .m_rdata(m_rdata), .m_err(m_err),
        .wr_count(wr_count), .last_waddr(last_waddr),
        .last_wdata(last_wdata)
    );

    // 100 MHz clock
    always #5 clk = ~clk;
    // Count acknowledge pulses of channel 5
    always @(posedge clk) if (!rst && periph_ack[5] === 1'b1) acks++;

    // Byte address of register idx in channel block ch
    function automatic logic [31:0] ra(input int ch, input int idx);
        return 32'hA0000008 + 32'(20 * ch + 4 * idx);
    endfunction
    task automatic chk(input string n, input logic [31:0] s,
                       input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    // One APB transfer; read data taken at the pready edge
    task automatic apb(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // Reserved bits are always written as zero
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input string n, input logic [31:0] a,
                       input logic [31:0] e);
        apb(1'b0, a, 32'h00000000);
        chk(n, rd_q, e);
    endtask
    // Poll until the masked value appears, bounded
    task automatic poll(input logic [31:0] a, input logic [31:0] m,
                        input logic [31:0] v);
        int n;
        n = 0;
        do begin
            apb(1'b0, a, 32'h00000000);
            n++;
        end while ((rd_q & m) !== v && n < 300);
        chk("poll", rd_q & m, v);
    endtask
    task automatic waitw(input int k);
        int n;
        for (n = 0; n < 200 && wr_count < k; n++) @(posedge clk);
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Watchdog well beyond the expected few hundred cycles
    initial begin
        #300000;
        num_errors++;
        end_of_test();
    end

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (i = 0; i < 8; i++)
            for (j = 0; j < 4; j++)
                rdc("reset", ra(i, j), 32'h00000000);
        apb(1'b0, 32'hA0000018, 32'h00000000);
        chk("unmapped", {31'h0, err_q}, 32'h00000001);
        chk("ready", {31'h0, pready}, 32'h00000001);
        // Copy on ch2: 16-bit memory items into a stepped 32-bit register
        wr(ra(2, 1), 32'h00000004);
        wr(ra(2, 2), 32'h20000103);
        wr(ra(2, 3), 32'h10000001);
        wr(ra(2, 0), 32'h000066C7);
        poll(ra(2, 1), 32'h0000FFFF, 32'h00000000);
        chk("items", 32'(wr_count), 32'h00000004);
        chk("dst addr", last_waddr, 32'h2000010C);
        chk("dst data", last_wdata, 32'h0000FFF9);
        rdc("flags", 32'hA0000000, 32'h00000700);
        chk("irq2", {31'h0, irq[2]}, 32'h00000001);
        wr(ra(2, 1), 32'h00000005);
        rdc("locked", ra(2, 1), 32'h00000000);
        chk("idle", 32'(wr_count), 32'h00000004);
        wr(32'hA0000004, 32'h00000200);
        rdc("flags", 32'hA0000000, 32'h00000500);
        wr(32'hA0000004, 32'h00000100);
        rdc("flags", 32'hA0000000, 32'h00000000);
        chk("irq2", {31'h0, irq[2]}, 32'h00000000);
        // Bus error on the first read of ch0
        wr(ra(0, 1), 32'h00000003);
        wr(ra(0, 2), 32'h20000000);
        wr(ra(0, 3), 32'hE0000000);
        wr(ra(0, 0), 32'h00004009);
        poll(ra(0, 0), 32'h00000001, 32'h00000000);
        rdc("err cfg", ra(0, 0), 32'h00004008);
        rdc("err count", ra(0, 1), 32'h00000003);
        rdc("err flags", 32'hA0000000, 32'h00000009);
        chk("irq0", {31'h0, irq[0]}, 32'h00000001);
        // Paced circular ch5 on a slow bus
        slow <= 1'b1;
        periph_req <= 8'h20;
        wr(ra(5, 1), 32'h00000002);
        wr(ra(5, 2), 32'h30000005);
        wr(ra(5, 3), 32'h10000040);
        wr(ra(5, 0), 32'h00001020);
        base = wr_count;
        repeat (20) @(posedge clk);
        chk("disabled", 32'(wr_count - base), 32'h00000000);
        wr(ra(5, 0), 32'h00001021);
        for (i = 0; i < 400 && acks < 5; i++) @(posedge clk);
        periph_req <= 8'h00;
        repeat (30) @(posedge clk);
        chk("acks", 32'(acks >= 5), 32'h00000001);
        rdc("reload", ra(5, 1),
            acks % 2 == 1 ? 32'h00000001 : 32'h00000002);
        chk("p2m addr", last_waddr, 32'h10000040);
        chk("p2m data", last_wdata, 32'h000000FA);
        chk("irq5", {31'h0, irq[5]}, 32'h00000000);
        // Low ch3 and very high ch6 ask together
        slow <= 1'b0;
        wr(ra(3, 1), 32'h00000001);
        wr(ra(3, 2), 32'h30000010);
        wr(ra(3, 3), 32'h10000080);
        wr(ra(3, 0), 32'h00000001);
        wr(ra(6, 1), 32'h00000001);
        wr(ra(6, 2), 32'h30000020);
        wr(ra(6, 3), 32'h10000090);
        wr(ra(6, 0), 32'h00003011);
        base = wr_count;
        periph_req <= 8'h48;
        waitw(base + 1);
        chk("first", last_waddr, 32'h30000020);
        waitw(base + 2);
        chk("second", last_waddr, 32'h10000080);
        periph_req <= 8'h00;
        end_of_test();
    end
endmodule
`default_nettype wire
